// File: src/adcf_apb.sv
`default_nettype none

module adcf_apb (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcf_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic wr_ctrl,
   input wire logic [31:0] ctrl_word,
   input wire logic [31:0] status_word,
   input wire logic [31:0] data_word,
   input wire logic [31:0] count_word
);

   logic [31:0] next_prdata;
   logic [31:0] rd_mux;
   logic mapped;

   // ----------------------------------------
   // Address decode and read mux
   // ----------------------------------------
   always_comb begin
      mapped = 1'b1;
      rd_mux = adcf_pkg::WORD_ZERO;
      case (paddr)
         adcf_pkg::CTRL_OFS: rd_mux = ctrl_word;
         adcf_pkg::STATUS_OFS: rd_mux = status_word;
         adcf_pkg::DATA_OFS: rd_mux = data_word;
         adcf_pkg::COUNT_OFS: rd_mux = count_word;
         default: mapped = 1'b0;
      endcase
      next_prdata = prdata;
      if (psel && !penable) begin
         next_prdata = rd_mux;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= adcf_pkg::WORD_ZERO;
      end else begin
         prdata <= next_prdata;
      end
   end

   // Zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wr_ctrl = psel && penable && pwrite && (paddr == adcf_pkg::CTRL_OFS);

endmodule : adcf_apb

`default_nettype wire

// File: src/adcf_coder.sv
`default_nettype none

module adcf_coder (
   input wire logic signed [adcf_pkg::DIFF_W-1:0] diff,
   input wire logic gain_select,
   input wire logic code_format_select,
   output logic [adcf_pkg::CODE_W-1:0] code
);

   logic signed [adcf_pkg::DIFF_W-1:0] scaled;
   logic signed [adcf_pkg::DIFF_W-1:0] clamped;
   logic [adcf_pkg::CODE_W-1:0] offset_bin;

   // Gain scaling, clamp, then output coding
   always_comb begin
      if (gain_select) begin
         scaled = diff >>> 1;
      end else begin
         scaled = diff;
      end
      if (scaled > signed'(adcf_pkg::DIFF_POS_MAX)) begin
         clamped = signed'(adcf_pkg::DIFF_POS_MAX);
      end else if (scaled < signed'(adcf_pkg::DIFF_NEG_MIN)) begin
         clamped = signed'(adcf_pkg::DIFF_NEG_MIN);
      end else begin
         clamped = scaled;
      end
      offset_bin = {~clamped[adcf_pkg::CODE_W-1], clamped[adcf_pkg::CODE_W-2:0]};
      if (code_format_select) begin
         code = {~offset_bin[adcf_pkg::CODE_W-1], offset_bin[adcf_pkg::CODE_W-2:0]};
      end else begin
         code = offset_bin;
      end
   end

endmodule : adcf_coder

`default_nettype wire

// File: src/adcf_pkg.sv
`default_nettype none

package adcf_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int CODE_W = 10;
   localparam int DIFF_W = 12;
   localparam int ADDR_W = 12;
   localparam int CNT_W = 16;

   // ----------------------------------------
   // Zero code of the output word and clamp limits of the difference
   // ----------------------------------------
   localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [DIFF_W-1:0] DIFF_POS_MAX = 12'h1FF;
   localparam logic [DIFF_W-1:0] DIFF_NEG_MIN = 12'hE00;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] DATA_OFS = 12'h008;
   localparam logic [ADDR_W-1:0] COUNT_OFS = 12'h00C;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Field positions
   localparam int CTRL_SOFT_STANDBY_BIT = 0;
   localparam int CTRL_SOFT_SLEEP_BIT = 1;
   localparam int DATA_Q_LSB = 16;
   localparam int STATUS_PINS_LSB = 4;
   localparam int STATUS_RUN_BIT = 2;

   // ----------------------------------------
   // Clock period and recovery times in nanoseconds, and recovery counts in clock cycles
   // ----------------------------------------
   localparam int CLK_PERIOD_TIME = 10;
   localparam int STANDBY_WAKE_TIME = 100;
   localparam int SLEEP_WAKE_TIME = 1000;
   localparam int STANDBY_WAKE_CYC = (STANDBY_WAKE_TIME + CLK_PERIOD_TIME - 1) / CLK_PERIOD_TIME;
   localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_TIME + CLK_PERIOD_TIME - 1) / CLK_PERIOD_TIME;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_RUN, MODE_STANDBY, MODE_SLEEP, MODE_WAKE} adcf_mode_t;

   typedef struct packed {
      logic sleep_request;
      logic standby_request;
      logic bus_layout_select;
      logic code_format_select;
      logic gain_select;
   } adcf_pins_t;

   typedef struct packed {
      logic soft_sleep;
      logic soft_standby;
   } adcf_ctrl_t;

endpackage : adcf_pkg

`default_nettype wire

// File: src/adcf_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`default_nettype none

// Function
// - Format low: offset binary codes
// - Format high: two's complement codes
// - Gain low: reference span fills code range
// - Gain high: twice reference fills range
// - Convert only with both requests low
// - Standby request enters quick-recovery standby
// - Standby freezes outputs at last result
// - Sleep request enters slow-recovery sleep
// - Sleep wins over standby
// - Sleep holds outputs at last result
// - Both channels sampled on falling edge
// - Layout select: parallel or interleaved buses
module adcf_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adcf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_clk,
   input wire logic signed [adcf_pkg::DIFF_W-1:0] diff_i,
   input wire logic signed [adcf_pkg::DIFF_W-1:0] diff_q,
   input wire logic code_format_select,
   input wire logic gain_select,
   input wire logic standby_request,
   input wire logic sleep_request,
   input wire logic bus_layout_select,
   output logic [adcf_pkg::CODE_W-1:0] bus_i,
   output logic [adcf_pkg::CODE_W-1:0] bus_q,
   output logic bus_q_phase,
   output logic bus_strobe
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   adcf_pkg::adcf_pins_t pins;
   adcf_pkg::adcf_ctrl_t ctrl;
   adcf_pkg::adcf_ctrl_t next_ctrl;
   adcf_pkg::adcf_mode_t mode;
   adcf_pkg::adcf_mode_t next_mode;
   logic [adcf_pkg::CNT_W-1:0] wake_cnt;
   logic [adcf_pkg::CNT_W-1:0] next_wake_cnt;
   logic sample_prev;
   logic next_sample_prev;
   logic sample_fall;
   logic sleep_eff;
   logic standby_eff;
   logic convert;
   logic wr_ctrl;
   logic signed [adcf_pkg::DIFF_W-1:0] diff_ch [2];
   logic [adcf_pkg::CODE_W-1:0] code_ch [2];
   logic [adcf_pkg::CODE_W-1:0] last_i;
   logic [adcf_pkg::CODE_W-1:0] last_q;
   logic [adcf_pkg::CODE_W-1:0] next_last_i;
   logic [adcf_pkg::CODE_W-1:0] next_last_q;
   logic [adcf_pkg::CODE_W-1:0] next_bus_i;
   logic [adcf_pkg::CODE_W-1:0] next_bus_q;
   logic next_bus_q_phase;
   logic next_bus_strobe;
   logic q_pending;
   logic next_q_pending;
   logic [31:0] conv_count;
   logic [31:0] next_conv_count;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] data_word;

   // ----------------------------------------
   // Control pins and effective requests
   // ----------------------------------------
   assign pins.sleep_request = sleep_request;
   assign pins.standby_request = standby_request;
   assign pins.bus_layout_select = bus_layout_select;
   assign pins.code_format_select = code_format_select;
   assign pins.gain_select = gain_select;

   // Software requests add to the pin requests
   assign sleep_eff = pins.sleep_request || ctrl.soft_sleep;
   assign standby_eff = pins.standby_request || ctrl.soft_standby;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   adcf_apb u_apb (
      .clk(clk),
      .sys_rst(sys_rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wr_ctrl(wr_ctrl),
      .ctrl_word(ctrl_word),
      .status_word(status_word),
      .data_word(data_word),
      .count_word(conv_count)
   );

   // Read views of the block state
   always_comb begin
      ctrl_word = adcf_pkg::WORD_ZERO;
      ctrl_word[adcf_pkg::CTRL_SOFT_STANDBY_BIT] = ctrl.soft_standby;
      ctrl_word[adcf_pkg::CTRL_SOFT_SLEEP_BIT] = ctrl.soft_sleep;
      // Mode code, run flag and live pin levels
      status_word = adcf_pkg::WORD_ZERO;
      status_word[1:0] = mode;
      status_word[adcf_pkg::STATUS_RUN_BIT] = (mode == adcf_pkg::MODE_RUN);
      status_word[adcf_pkg::STATUS_PINS_LSB +: 5] = pins;
      data_word = adcf_pkg::WORD_ZERO;
      data_word[adcf_pkg::CODE_W-1:0] = last_i;
      data_word[adcf_pkg::DATA_Q_LSB +: adcf_pkg::CODE_W] = last_q;
   end

   // Control register next value
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         // Only the two request bits are stored
         next_ctrl.soft_standby = pwdata[adcf_pkg::CTRL_SOFT_STANDBY_BIT];
         next_ctrl.soft_sleep = pwdata[adcf_pkg::CTRL_SOFT_SLEEP_BIT];
      end
   end

   // Control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= adcf_pkg::adcf_ctrl_t'(adcf_pkg::CTRL_RST[1:0]);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ----------------------------------------
   // Power mode sequencer
   // ----------------------------------------
   always_comb begin
      next_mode = mode;
      next_wake_cnt = wake_cnt;
      // Sleep is tested first in every state so it outranks standby
      case (mode)
         adcf_pkg::MODE_RUN: begin
            if (sleep_eff) begin
               next_mode = adcf_pkg::MODE_SLEEP;
            end else if (standby_eff) begin
               next_mode = adcf_pkg::MODE_STANDBY;
            end
         end
         // Standby leaves through the short recovery count
         adcf_pkg::MODE_STANDBY: begin
            if (sleep_eff) begin
               next_mode = adcf_pkg::MODE_SLEEP;
            end else if (!standby_eff) begin
               next_mode = adcf_pkg::MODE_WAKE;
               next_wake_cnt = adcf_pkg::CNT_W'(adcf_pkg::STANDBY_WAKE_CYC - 1);
            end
         end
         // Sleep released with standby held drops to standby only
         adcf_pkg::MODE_SLEEP: begin
            if (!sleep_eff && standby_eff) begin
               next_mode = adcf_pkg::MODE_STANDBY;
            end else if (!sleep_eff) begin
               next_mode = adcf_pkg::MODE_WAKE;
               next_wake_cnt = adcf_pkg::CNT_W'(adcf_pkg::SLEEP_WAKE_CYC - 1);
            end
         end
         // Recovery: a new request aborts it, else count down to run
         adcf_pkg::MODE_WAKE: begin
            if (sleep_eff) begin
               next_mode = adcf_pkg::MODE_SLEEP;
            end else if (standby_eff) begin
               next_mode = adcf_pkg::MODE_STANDBY;
            end else if (wake_cnt == '0) begin
               next_mode = adcf_pkg::MODE_RUN;
            end else begin
               next_wake_cnt = wake_cnt - 1'b1;
            end
         end
         default: begin
            next_mode = adcf_pkg::MODE_RUN;
         end
      endcase
   end

   // Mode state and recovery counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode <= adcf_pkg::MODE_RUN;
         wake_cnt <= '0;
      end else begin
         mode <= next_mode;
         wake_cnt <= next_wake_cnt;
      end
   end

   // ----------------------------------------
   // Sample instant
   // ----------------------------------------
   // Sample clock is a synchronous input; its fall is found here
   assign next_sample_prev = sample_clk;
   assign sample_fall = sample_prev && !sample_clk;
   // A conversion needs the run state and no live request
   assign convert = sample_fall && (mode == adcf_pkg::MODE_RUN) && !sleep_eff && !standby_eff;

   // Previous level of the sample clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample_prev <= 1'b0;
      end else begin
         sample_prev <= next_sample_prev;
      end
   end

   // ----------------------------------------
   // Channel coders, both fed the same instant
   // ----------------------------------------
   assign diff_ch[0] = diff_i;
   assign diff_ch[1] = diff_q;

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         adcf_coder u_coder (
            .diff(diff_ch[ch]),
            .gain_select(pins.gain_select),
            .code_format_select(pins.code_format_select),
            .code(code_ch[ch])
         );
      end
   endgenerate

   // ----------------------------------------
   // Result capture and output buses
   // ----------------------------------------
   always_comb begin
      next_last_i = last_i;
      next_last_q = last_q;
      next_bus_i = bus_i;
      next_bus_q = bus_q;
      next_bus_q_phase = bus_q_phase;
      next_bus_strobe = 1'b0;
      next_q_pending = 1'b0;
      next_conv_count = conv_count;
      // A fall in the Q slot of an interleaved pair drops that Q word
      if (convert) begin
         // Both channels latched together
         next_last_i = code_ch[0];
         next_last_q = code_ch[1];
         next_conv_count = conv_count + 32'h0000_0001;
         next_bus_i = code_ch[0];
         next_bus_q_phase = 1'b0;
         next_bus_strobe = 1'b1;
         if (pins.bus_layout_select) begin
            next_bus_q = code_ch[1];
         end else begin
            next_q_pending = 1'b1;
         end
      end else if (q_pending) begin
         // Second word of an interleaved pair
         next_bus_i = last_q;
         next_bus_q_phase = 1'b1;
         next_bus_strobe = 1'b1;
      end
      // Frozen otherwise: standby and sleep keep last result
      if (!pins.bus_layout_select) begin
         next_bus_q = adcf_pkg::CODE_ZERO;
      end
   end

   // Result and bus registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_i <= adcf_pkg::CODE_ZERO;
         last_q <= adcf_pkg::CODE_ZERO;
         bus_i <= adcf_pkg::CODE_ZERO;
         bus_q <= adcf_pkg::CODE_ZERO;
         bus_q_phase <= 1'b0;
         bus_strobe <= 1'b0;
         q_pending <= 1'b0;
         conv_count <= adcf_pkg::WORD_ZERO;
      end else begin
         last_i <= next_last_i;
         last_q <= next_last_q;
         bus_i <= next_bus_i;
         bus_q <= next_bus_q;
         bus_q_phase <= next_bus_q_phase;
         bus_strobe <= next_bus_strobe;
         q_pending <= next_q_pending;
         conv_count <= next_conv_count;
      end
   end

endmodule : adcf_top

`default_nettype wire

// File: test/adcf_props.sv
`default_nettype none

module adcf_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sample_clk,
   input wire logic standby_request,
   input wire logic sleep_request,
   input wire logic bus_layout_select,
   input wire logic [adcf_pkg::CODE_W-1:0] bus_i,
   input wire logic [adcf_pkg::CODE_W-1:0] bus_q,
   input wire logic bus_q_phase,
   input wire logic bus_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Helper: sample edge, time since requests
   // ----------------------------------------
   logic prev_s;
   logic fall;
   logic [7:0] quiet;
   logic [7:0] next_quiet;
   // Falling edge of the sample clock
   assign fall = prev_s && !sample_clk;
   // Saturating count of request-free cycles
   always_comb begin
      next_quiet = quiet;
      if (sys_rst || standby_request || sleep_request) begin
         next_quiet = 8'h00;
      end else if (quiet != 8'hFF) begin
         next_quiet = quiet + 8'h01;
      end
   end
   // Register helper state
   always_ff @(posedge clk) begin
      prev_s <= sample_clk;
      quiet <= next_quiet;
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_q_word;
      bus_strobe && bus_q_phase;
   endsequence
   a_rst_clear: assert property ($past(sys_rst) |-> !bus_strobe && bus_i == 10'h000)
      else $error("outputs not clear after reset");
   a_fall_cause: assert property (bus_strobe && !bus_q_phase |-> $past(fall))
      else $error("word without sample fall");
   a_run_conv: assert property (fall && quiet > 8'h6E && !standby_request && !sleep_request
      |=> bus_strobe && !bus_q_phase)
      else $error("no word after sample fall");
   a_sleep_quiet: assert property (sleep_request && $past(sleep_request)
      |=> !bus_strobe && $stable(bus_i))
      else $error("word during sleep");
   a_standby_request_hold: assert property (standby_request && $past(standby_request)
      |=> $stable(bus_i) && !bus_strobe)
      else $error("output moved in standby");
   a_q_low: assert property (!bus_layout_select && !$past(bus_layout_select)
      |-> bus_q == 10'h000)
      else $error("second bus not low");
   a_mux_pair: assert property (bus_strobe && !bus_q_phase && !$past(bus_layout_select)
      |=> s_q_word)
      else $error("second word missing");
   a_par_single: assert property (bus_layout_select && $past(bus_layout_select)
      && $past(bus_layout_select, 2) |-> !(bus_strobe && bus_q_phase))
      else $error("second word in parallel layout");
endmodule : adcf_props

bind adcf_top adcf_props u_props (.clk, .sys_rst, .sample_clk, .standby_request,
   .sleep_request, .bus_layout_select, .bus_i, .bus_q, .bus_q_phase, .bus_strobe);

`default_nettype wire

// File: test/adcf_sink.sv
`default_nettype none

module adcf_sink (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [adcf_pkg::CODE_W-1:0] bus_i,
   input wire logic [adcf_pkg::CODE_W-1:0] bus_q,
   input wire logic bus_q_phase,
   input wire logic bus_strobe,
   output logic [adcf_pkg::CODE_W-1:0] cap_i,
   output logic [adcf_pkg::CODE_W-1:0] cap_q,
   output logic [15:0] cap_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Capture each word on its strobe; second word of a pair is Q
   always @(posedge clk) begin
      if (sys_rst) begin
         cap_i <= 10'h000;
         cap_q <= 10'h000;
         cap_n <= 16'h0000;
      end else if (bus_strobe && bus_q_phase) begin
         cap_q <= bus_i;
      end else if (bus_strobe) begin
         cap_i <= bus_i;
         cap_q <= bus_q;
         cap_n <= cap_n + 16'h0001;
      end
   end
endmodule : adcf_sink

`default_nettype wire

// File: test/tb_top.sv
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t: got %h exp %h", $time, a, b); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic sample_clk, code_format_select, gain_select, standby_request, sleep_request;
   logic bus_layout_select, bus_q_phase, bus_strobe;
   logic [adcf_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [adcf_pkg::DIFF_W-1:0] diff_i, diff_q;
   logic [adcf_pkg::CODE_W-1:0] bus_i, bus_q, cap_i, cap_q;
   logic [15:0] cap_n, n0;
   logic signed [adcf_pkg::DIFF_W-1:0] vals [8] = '{12'h7FF, 12'h3FF, 12'h1FF, 12'h000,
      12'hFFF, 12'hE00, 12'hC00, 12'h800};
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;

   adcf_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sample_clk, .diff_i, .diff_q, .code_format_select, .gain_select,
      .standby_request, .sleep_request, .bus_layout_select, .bus_i, .bus_q, .bus_q_phase,
      .bus_strobe);
   adcf_sink sink (.clk, .sys_rst, .bus_i, .bus_q, .bus_q_phase, .bus_strobe, .cap_i, .cap_q,
      .cap_n);

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         final_report();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One sample clock pulse with new inputs, then settle
   task automatic conv(input logic signed [11:0] i, input logic signed [11:0] q);
      @(posedge clk);
      diff_i <= i;
      diff_q <= q;
      sample_clk <= 1'b1;
      repeat (2) @(posedge clk);
      sample_clk <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : conv

   // Expected code from span, clamp and format
   function automatic logic [9:0] ecode(logic signed [11:0] d, logic g, logic f);
      logic signed [11:0] v;
      v = g ? d >>> 1 : d;
      if (v > $signed(adcf_pkg::DIFF_POS_MAX)) v = adcf_pkg::DIFF_POS_MAX;
      if (v < $signed(adcf_pkg::DIFF_NEG_MIN)) v = adcf_pkg::DIFF_NEG_MIN;
      return {v[9] ^ !f, v[8:0]};
   endfunction : ecode

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {sys_rst, psel, penable, pwrite, sample_clk, code_format_select, gain_select} = 7'h7F;
      {psel, penable, pwrite, sample_clk, code_format_select, gain_select} = '0;
      {standby_request, sleep_request, bus_layout_select} = 3'h1;
      paddr = '0;
      pwdata = '0;
      diff_i = '0;
      diff_q = '0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, adcf_pkg::CTRL_OFS, 32'h0000_0000);
      `CHK(rd, adcf_pkg::CTRL_RST)
      apb(1'b1, adcf_pkg::CTRL_OFS, 32'h0000_0001);
      apb(1'b0, adcf_pkg::STATUS_OFS, 32'h0000_0000);
      `CHK(rd[1:0], 2'h1)
      apb(1'b1, adcf_pkg::CTRL_OFS, 32'h0000_0003);
      apb(1'b0, adcf_pkg::STATUS_OFS, 32'h0000_0000);
      `CHK(rd[1:0], 2'h2)
      apb(1'b1, adcf_pkg::CTRL_OFS, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
      repeat (120) @(posedge clk);
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         gain_select <= k[1];
         code_format_select <= k[0];
         foreach (vals[j]) begin
            conv(vals[j], ~vals[j]);
            `CHK(cap_i, ecode(vals[j], k[1], k[0]))
            `CHK(cap_q, ecode(~vals[j], k[1], k[0]))
         end
      end
      apb(1'b0, adcf_pkg::DATA_OFS, 32'h0000_0000);
      `CHK(rd[9:0], ecode(12'h800, 1'b1, 1'b1))
      $display("test codes done");
      bus_layout_select <= 1'b0;
      n0 = cap_n;
      conv(12'h100, 12'hF00);
      `CHK({cap_n, cap_i, cap_q, bus_q}, {n0 + 16'h0001, 10'h080, 10'h380, 10'h000})
      bus_layout_select <= 1'b1;
      standby_request <= 1'b1;
      repeat (2) @(posedge clk);
      n0 = cap_n;
      conv(12'h050, 12'h060);
      `CHK({cap_n, cap_i}, {n0, 10'h080})
      standby_request <= 1'b0;
      repeat (15) @(posedge clk);
      conv(12'h050, 12'h060);
      `CHK(cap_n, n0 + 16'h0001)
      {standby_request, sleep_request} <= 2'h3;
      repeat (2) @(posedge clk);
      apb(1'b0, adcf_pkg::STATUS_OFS, 32'h0000_0000);
      `CHK(rd[1:0], 2'h2)
      conv(12'h020, 12'h020);
      `CHK(cap_n, n0 + 16'h0001)
      {standby_request, sleep_request} <= 2'h0;
      repeat (15) @(posedge clk);
      conv(12'h020, 12'h020);
      `CHK(cap_n, n0 + 16'h0001)
      repeat (100) @(posedge clk);
      conv(12'h020, 12'h020);
      `CHK({cap_n, cap_i}, {n0 + 16'h0002, 10'h010})
      apb(1'b0, adcf_pkg::COUNT_OFS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0023)
      apb(1'b0, adcf_pkg::STATUS_OFS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0074)
      $display("test power modes done");
      final_report();
   end
endmodule : tb_top

`default_nettype wire
